// ---- rtl/indicator_pkg.sv ----
package indicator_pkg;

  // Management register addresses, five bits wide as on the management frame.
  localparam logic [4:0] INDICATOR_CONTROL_ADDR = 5'h18;
  localparam logic [4:0] PHY_CONTROL_ADDR       = 5'h19;

  // Field positions in the indicator control register.
  localparam int ACT_RX_ONLY_BIT  = 8;
  localparam int FLASH_RATE_HI    = 7;
  localparam int FLASH_RATE_LO    = 6;
  localparam int OVR_ENABLE_HI    = 5;
  localparam int OVR_ENABLE_LO    = 3;
  localparam int OVR_VALUE_HI     = 2;
  localparam int OVR_VALUE_LO     = 0;

  // Field positions in the PHY control register.
  localparam int MODE_SELECT_HI   = 6;
  localparam int MODE_SELECT_LO   = 5;

  // Reset values of the software fields.
  localparam logic       ACT_RX_ONLY_RESET = 1'b0;
  localparam logic [1:0] FLASH_RATE_RESET  = 2'h0;
  localparam logic [2:0] OVR_ENABLE_RESET  = 3'h0;
  localparam logic [2:0] OVR_VALUE_RESET   = 3'h0;
  localparam logic       MODE_HIGH_RESET   = 1'b0;

  // Indicator index within the three-pin group.
  localparam int LINK_IDX = 0;
  localparam int RATE_IDX = 1;
  localparam int ACT_IDX  = 2;

  // Consecutive normal link pulses needed to bring a 10 Mb/s link up.
  localparam logic [2:0] NLP_LINK_COUNT = 3'h7;

  // Cycles after reset release before straps are taken, covering the synchroniser.
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  // Clock and link-loss timing.
  localparam int CLK_PERIOD_NS       = 4;
  localparam int LINK_LOSS_NS        = 50000000;
  localparam int LINK_LOSS_CYCLES    = LINK_LOSS_NS / CLK_PERIOD_NS;
  localparam int LOSS_CNT_WIDTH      = 24;

  // Free-running flash divider and the tap used for each rate code.
  localparam int DIV_WIDTH           = 26;
  localparam int FLASH_TAP_0         = 25;
  localparam int FLASH_TAP_1         = 24;
  localparam int FLASH_TAP_2         = 23;
  localparam int FLASH_TAP_3         = 22;

  // Decoded indicator mode.
  typedef enum logic [1:0] {
    MODE_ACTIVITY,
    MODE_COLLISION,
    MODE_DUPLEX
  } indicator_mode_t;

  // Control sequence: straps first, then normal driving.
  typedef enum logic [0:0] {
    ST_STRAP,
    ST_RUN
  } ctrl_state_t;

endpackage : indicator_pkg

// ---- rtl/port_led_indicator_control.sv ----
`timescale 1ns/1ps
module port_led_indicator_control
  import indicator_pkg::*;
#(
  parameter int LOSS_CYCLES = LINK_LOSS_CYCLES
)
(
  // Clock, reset and clock enable.
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Management register port.
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Port status from the PHY core.
  input  wire logic        nlp_seen,
  input  wire logic        nlp_bad,
  input  wire logic        packet_10_ok,
  input  wire logic        signal_detect_100,
  input  wire logic        speed_100,
  input  wire logic        duplex_full,
  input  wire logic        tx_active,
  input  wire logic        rx_active,
  input  wire logic        mii_collision,
  // Carrier-sense pin strap.
  input  wire logic        port_carrier_strap_pin,
  // Indicator pins, shared with auto-negotiation straps.
  input  wire logic        link_indicator_pin_i,
  output logic             link_indicator_pin_o,
  output logic             link_indicator_pin_oe,
  input  wire logic        rate_indicator_pin_i,
  output logic             rate_indicator_pin_o,
  output logic             rate_indicator_pin_oe,
  input  wire logic        activity_collision_indicator_pin_i,
  output logic             activity_collision_indicator_pin_o,
  output logic             activity_collision_indicator_pin_oe,
  // 10 Mb/s link state for other logic.
  output logic             link_up
);

  // Map the two select bits to a mode; the low bit dominates.
  function automatic indicator_mode_t decode_mode(input logic [1:0] sel);
    if (sel[0])
      decode_mode = MODE_ACTIVITY;
    else if (sel[1])
      decode_mode = MODE_DUPLEX;
    else
      decode_mode = MODE_COLLISION;
  endfunction : decode_mode

  // Pick the divider tap that sets the flash period for a rate code.
  function automatic logic flash_phase(input logic [DIV_WIDTH-1:0] div,
                                       input logic [1:0]           rate);
    case (rate)
      2'h0:    flash_phase = div[FLASH_TAP_0];
      2'h1:    flash_phase = div[FLASH_TAP_1];
      2'h2:    flash_phase = div[FLASH_TAP_2];
      default: flash_phase = div[FLASH_TAP_3];
    endcase
  endfunction : flash_phase

  // The whole state of the block.
  typedef struct packed {
    ctrl_state_t               state;        // Strap phase or running.
    logic [1:0]                settle;       // Cycles spent waiting for straps.
    logic [2:0]                pin_meta;     // First synchroniser stage, pins.
    logic [2:0]                pin_sync;     // Second synchroniser stage, pins.
    logic                      cs_meta;      // First synchroniser stage, strap.
    logic                      cs_sync;      // Second synchroniser stage, strap.
    logic [2:0]                polarity;     // One means active-low pin.
    logic [1:0]                mode_sel;     // Indicator mode select.
    logic                      act_rx_only;  // Activity for the link-pin flash counts receive only.
    logic [1:0]                flash_rate;   // Flash rate select.
    logic [2:0]                ovr_en;       // Per-pin override enable.
    logic [2:0]                ovr_val;      // Per-pin forced value.
    logic [2:0]                nlp_cnt;      // Consecutive good link pulses.
    logic                      link10;       // 10 Mb/s link state.
    logic [LOSS_CNT_WIDTH-1:0] loss_cnt;     // Link-loss timer.
    logic [DIV_WIDTH-1:0]      div;          // Free-running flash divider.
    logic [2:0]                pin_out;      // Registered pin levels.
    logic                      pin_oe;       // Registered pin enable.
    logic [15:0]               rdata;        // Registered read data.
  } led_state_t;

  led_state_t      st_reg;       // Current state.
  led_state_t      st_next;      // Next state.
  indicator_mode_t mode;         // Decoded mode.
  logic            activity;     // Activity under the chosen definition.
  logic            link_good;    // Link state at the current speed.
  logic            collision;    // Collision shown on the third pin.
  logic [2:0]      led_value;    // Logical indicator values, one means on.
  logic [2:0]      led_final;    // Values after override.
  logic [LOSS_CNT_WIDTH-1:0] loss_limit;  // Link-loss count at timer width.

  assign loss_limit = LOSS_CYCLES[LOSS_CNT_WIDTH-1:0];

  // Work out the next state and the indicator values.
  always_comb
  begin
    st_next = st_reg;
    mode    = decode_mode(st_reg.mode_sel);

    // Activity is transmit or receive unless receive-only is chosen.
    activity = st_reg.act_rx_only ? rx_active : (tx_active | rx_active);

    // At 100 Mb/s the link follows signal detect directly.
    link_good = speed_100 ? signal_detect_100 : st_reg.link10;

    // In half duplex the MII collision is what the pin shows; full duplex has none.
    collision = mii_collision & ~duplex_full;

    // Link pin: steady when select bit 0 is set (modes 1 and 3), flashing with activity in modes 0 and 2.
    if (mode == MODE_ACTIVITY)
    begin
      led_value[LINK_IDX] = link_good;
    end
    else
    begin
      led_value[LINK_IDX] = link_good &
        (~activity | flash_phase(st_reg.div, st_reg.flash_rate));
    end

    // Rate pin does not depend on the mode.
    led_value[RATE_IDX] = speed_100;

    // Third pin meaning depends on the mode.
    case (mode)
      MODE_ACTIVITY:  led_value[ACT_IDX] = tx_active | rx_active;
      MODE_COLLISION: led_value[ACT_IDX] = collision;
      MODE_DUPLEX:    led_value[ACT_IDX] = duplex_full;
      default:        led_value[ACT_IDX] = 1'b0;
    endcase

    // A forced value replaces the computed one before polarity.
    led_final = (st_reg.ovr_en & st_reg.ovr_val) | (~st_reg.ovr_en & led_value);

    // Synchronisers: the first stage feeds only the second.
    st_next.pin_meta = {activity_collision_indicator_pin_i, rate_indicator_pin_i,
                        link_indicator_pin_i};
    st_next.pin_sync = st_reg.pin_meta;
    st_next.cs_meta  = port_carrier_strap_pin;
    st_next.cs_sync  = st_reg.cs_meta;

    // Flash divider runs freely.
    st_next.div = st_reg.div + 1'b1;

    // The 10 Mb/s link comes up on seven good pulses or a good packet.
    if (nlp_bad)
    begin
      st_next.nlp_cnt = 3'h0;
    end
    else if (nlp_seen && st_reg.nlp_cnt != NLP_LINK_COUNT)
    begin
      st_next.nlp_cnt = st_reg.nlp_cnt + 3'h1;
    end
    if (packet_10_ok || (nlp_seen && !nlp_bad && st_reg.nlp_cnt == NLP_LINK_COUNT - 3'h1))
    begin
      st_next.link10 = 1'b1;
    end

    // Link-loss timer restarts on any link evidence; only its expiry drops the link.
    if (nlp_seen || packet_10_ok)
    begin
      st_next.loss_cnt = '0;
    end
    else if (st_reg.link10)
    begin
      if (st_reg.loss_cnt >= loss_limit - 1'b1)
      begin
        st_next.link10  = 1'b0;
        st_next.nlp_cnt = 3'h0;
        st_next.loss_cnt = '0;
      end
      else
      begin
        st_next.loss_cnt = st_reg.loss_cnt + 1'b1;
      end
    end

    // Straps are taken once the synchronisers hold post-reset pin levels.
    case (st_reg.state)
      ST_STRAP:
      begin
        st_next.pin_oe = 1'b0;
        if (st_reg.settle == STRAP_SETTLE_CYCLES)
        begin
          st_next.polarity    = st_reg.pin_sync;
          st_next.mode_sel[0] = st_reg.cs_sync;
          st_next.state       = ST_RUN;
          st_next.pin_oe      = 1'b1;
        end
        else
        begin
          st_next.settle = st_reg.settle + 2'h1;
        end
      end
      ST_RUN:
      begin
        // A strap read low gives an active-high pin, high gives active-low.
        st_next.pin_out = led_final ^ st_reg.polarity;
        st_next.pin_oe  = 1'b1;
      end
      default:
      begin
        st_next.state = ST_STRAP;
      end
    endcase

    // Register writes; a PHY control write during the strap phase is ignored.
    if (reg_wr)
    begin
      if (reg_addr == INDICATOR_CONTROL_ADDR)
      begin
        st_next.act_rx_only = reg_wdata[ACT_RX_ONLY_BIT];
        st_next.flash_rate  = reg_wdata[FLASH_RATE_HI:FLASH_RATE_LO];
        st_next.ovr_en      = reg_wdata[OVR_ENABLE_HI:OVR_ENABLE_LO];
        st_next.ovr_val     = reg_wdata[OVR_VALUE_HI:OVR_VALUE_LO];
      end
      else if (reg_addr == PHY_CONTROL_ADDR && st_reg.state == ST_RUN)
      begin
        st_next.mode_sel = reg_wdata[MODE_SELECT_HI:MODE_SELECT_LO];
      end
    end

    // Reads return stored settings, never the pin levels.
    if (reg_rd)
    begin
      st_next.rdata = 16'h0000;
      if (reg_addr == INDICATOR_CONTROL_ADDR)
      begin
        st_next.rdata[ACT_RX_ONLY_BIT]             = st_reg.act_rx_only;
        st_next.rdata[FLASH_RATE_HI:FLASH_RATE_LO] = st_reg.flash_rate;
        st_next.rdata[OVR_ENABLE_HI:OVR_ENABLE_LO] = st_reg.ovr_en;
        st_next.rdata[OVR_VALUE_HI:OVR_VALUE_LO]   = st_reg.ovr_val;
      end
      else if (reg_addr == PHY_CONTROL_ADDR)
      begin
        st_next.rdata[MODE_SELECT_HI:MODE_SELECT_LO] = st_reg.mode_sel;
      end
    end
  end

  // Register the state; the clock enable freezes everything but reset when low.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_reg             <= '0;
      st_reg.state       <= ST_STRAP;
      st_reg.act_rx_only <= ACT_RX_ONLY_RESET;
      st_reg.flash_rate  <= FLASH_RATE_RESET;
      st_reg.ovr_en      <= OVR_ENABLE_RESET;
      st_reg.ovr_val     <= OVR_VALUE_RESET;
      st_reg.mode_sel    <= {MODE_HIGH_RESET, 1'b0};
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops.
  assign reg_rdata                           = st_reg.rdata;
  assign link_indicator_pin_o                = st_reg.pin_out[LINK_IDX];
  assign rate_indicator_pin_o                = st_reg.pin_out[RATE_IDX];
  assign activity_collision_indicator_pin_o  = st_reg.pin_out[ACT_IDX];
  assign link_indicator_pin_oe               = st_reg.pin_oe;
  assign rate_indicator_pin_oe               = st_reg.pin_oe;
  assign activity_collision_indicator_pin_oe = st_reg.pin_oe;
  assign link_up                             = st_reg.link10;

endmodule : port_led_indicator_control

// ---- verif/led_strap_model.sv ----
`timescale 1ns/1ps
// Board side of the three shared pins: strap resistors, each with an LED.
module led_strap_model #(
  parameter logic [2:0] PULL = 3'h5  // Resistor level on each pin.
)
(
  // Design drive on the pins.
  input  wire logic [2:0] drv_o,
  input  wire logic [2:0] drv_oe,
  // Pin levels seen by the design and LED light state.
  output logic      [2:0] level,
  output logic      [2:0] lit
);
  // A released pin rests at its resistor level, which is the strap value.
  assign level = (drv_oe & drv_o) | (~drv_oe & PULL);
  // An LED lights when the pin is driven away from its resistor level.
  assign lit   = drv_oe & (drv_o ^ PULL);
endmodule : led_strap_model

// ---- verif/led_chk.sv ----
`timescale 1ns/1ps
module led_chk
  import indicator_pkg::*;
#(
  parameter int LOSS_CYCLES = 64
)
(
  // Clock, reset and register port.
  input wire logic        core_clk, rst_n, clk_en, reg_wr, reg_rd,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata,
  // Port status.
  input wire logic        nlp_seen, packet_10_ok, signal_detect_100, speed_100,
  input wire logic        duplex_full, tx_active, rx_active, mii_collision,
  // Straps and indicator pins.
  input wire logic        port_carrier_strap_pin, link_up,
  input wire logic        link_indicator_pin_i, link_indicator_pin_o, link_indicator_pin_oe,
  input wire logic        rate_indicator_pin_i, rate_indicator_pin_o, rate_indicator_pin_oe,
  input wire logic        activity_collision_indicator_pin_i,
  input wire logic        activity_collision_indicator_pin_o,
  input wire logic        activity_collision_indicator_pin_oe
);
  logic [2:0] pol_q;    // Strap levels taken while the pins float.
  logic [1:0] mode_q;   // Mode select as strap and software left it.
  logic [8:0] ctl_q;    // Indicator control fields.
  logic [2:0] rel_q;    // Enabled edges since reset release, saturating.
  int         quiet_q;  // Enabled cycles without link evidence.
  logic       act_exp;  // Third pin value expected from the status inputs.
  logic       link_exp; // Mode 1 link pin value expected.

  assign act_exp  = mode_q[0] ? (tx_active | rx_active) :
                    mode_q[1] ? duplex_full : (mii_collision & ~duplex_full);
  assign link_exp = speed_100 ? signal_detect_100 : link_up;

  // Shadow of the register and strap state; the straps are steady during a run.
  always_ff @(posedge core_clk)
  begin
    if (!link_indicator_pin_oe)
      pol_q <= {activity_collision_indicator_pin_i, rate_indicator_pin_i, link_indicator_pin_i};
    if (!rst_n)
    begin
      mode_q  <= 2'h0;
      ctl_q   <= 9'h000;
      rel_q   <= 3'h0;
      quiet_q <= 0;
    end
    else if (clk_en)
    begin
      rel_q   <= (rel_q == 3'h7) ? rel_q : rel_q + 3'h1;
      quiet_q <= (nlp_seen || packet_10_ok) ? 0 : ((quiet_q > 9999) ? quiet_q : quiet_q + 1);
      if (reg_wr && reg_addr == INDICATOR_CONTROL_ADDR)
        ctl_q <= reg_wdata[8:0];
      if (!link_indicator_pin_oe)
        mode_q[0] <= port_carrier_strap_pin;
      else if (reg_wr && reg_addr == PHY_CONTROL_ADDR)
        mode_q <= reg_wdata[6:5];
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Running pin with no software override in force.
  sequence s_run(logic oe, logic ovr);
    clk_en && oe && !ovr;
  endsequence

  a_rate_speed: assert property (s_run(rate_indicator_pin_oe, ctl_q[4]) |=>
    rate_indicator_pin_o == ($past(speed_100) ^ pol_q[1])) else $error("rate pin wrong");
  a_link_mode1: assert property (s_run(link_indicator_pin_oe, ctl_q[3]) ##0 mode_q[0] |=>
    link_indicator_pin_o == ($past(link_exp) ^ pol_q[0])) else $error("link pin wrong");
  a_third_pin_mode: assert property (
    s_run(activity_collision_indicator_pin_oe, ctl_q[5]) |=>
    activity_collision_indicator_pin_o == ($past(act_exp) ^ pol_q[2]))
    else $error("third pin wrong");
  a_override_link: assert property (clk_en && link_indicator_pin_oe && ctl_q[3] |=>
    link_indicator_pin_o == ($past(ctl_q[0]) ^ pol_q[0])) else $error("override ignored");
  a_drive_after_strap: assert property (link_indicator_pin_oe == (rel_q >= 3'h4) &&
    rate_indicator_pin_oe == link_indicator_pin_oe &&
    activity_collision_indicator_pin_oe == link_indicator_pin_oe) else $error("pin enable wrong");
  a_link_cause: assert property ($rose(link_up) |-> $past(nlp_seen || packet_10_ok))
    else $error("link rose without evidence");
  a_link_loss_wait: assert property ($fell(link_up) |-> quiet_q >= LOSS_CYCLES - 2)
    else $error("link dropped early");
  a_link_loss_hold: assert property (link_up && quiet_q < LOSS_CYCLES - 2 |=> link_up)
    else $error("link lost while evidence recent");
  a_unmapped_read: assert property (clk_en && reg_rd && reg_addr != 5'h18 &&
    reg_addr != 5'h19 |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!(clk_en && reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved without read");
endmodule : led_chk

bind port_led_indicator_control led_chk #(.LOSS_CYCLES(LOSS_CYCLES)) chk (.*);

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import indicator_pkg::*;
  localparam int         LOSS = 64;   // Short link-loss time keeps the run brief.
  localparam logic [2:0] PULL = 3'h5; // Link and third pin pulled up, rate pin pulled down.
  logic        core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, lk10 = 1'b0;
  logic        nlp = 1'b0, bad = 1'b0, pkt = 1'b0, sd = 1'b0, spd = 1'b0, dup = 1'b0;
  logic        tx = 1'b0, rx = 1'b0, col = 1'b0, link_up;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_q, d;
  logic [2:0]  pin_o, pin_oe, pin_lvl, lit;
  logic [1:0]  mode;
  logic [8:0]  ctl;
  int          mismatches = 0, tests_run = 0, seed = 63, cycles = 0;

  port_led_indicator_control #(.LOSS_CYCLES(LOSS)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nlp_seen(nlp), .nlp_bad(bad), .packet_10_ok(pkt), .signal_detect_100(sd),
    .speed_100(spd), .duplex_full(dup), .tx_active(tx), .rx_active(rx), .mii_collision(col),
    .port_carrier_strap_pin(1'b1), .link_up(link_up),
    .link_indicator_pin_i(pin_lvl[0]), .link_indicator_pin_o(pin_o[0]),
    .link_indicator_pin_oe(pin_oe[0]), .rate_indicator_pin_i(pin_lvl[1]),
    .rate_indicator_pin_o(pin_o[1]), .rate_indicator_pin_oe(pin_oe[1]),
    .activity_collision_indicator_pin_i(pin_lvl[2]),
    .activity_collision_indicator_pin_o(pin_o[2]),
    .activity_collision_indicator_pin_oe(pin_oe[2]));
  led_strap_model #(.PULL(PULL)) leds (.drv_o(pin_o), .drv_oe(pin_oe), .level(pin_lvl), .lit(lit));

  always #2 core_clk = ~core_clk;

  // A hang is cut short well beyond the expected run of under a thousand cycles.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      results();
    end
  end

  // Inputs always move one nanosecond after the rising edge.
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic wr(logic [4:0] a, logic [15:0] v);
    // The strobe drops for one full cycle so that a following call never
    // raises it again in the same time step.
    reg_addr = a; reg_wdata = v; reg_wr = 1'b1; step(1); reg_wr = 1'b0; step(1);
  endtask : wr
  task automatic rd(logic [4:0] a);
    // Data is taken just after the edge that accepted the read, then a gap cycle.
    reg_addr = a; reg_rd = 1'b1; step(1); reg_rd = 1'b0; rd_q = reg_rdata; step(1);
  endtask : rd
  task automatic chk_val(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_led(logic [2:0] exp);
    tests_run++;
    if (lit !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: lamps %b expected %b", $time, lit, exp);
    end
  endtask : chk_led
  task automatic pulses(int n);
    repeat (n)
    begin
      nlp = 1'b1; step(1); nlp = 1'b0; step(3);
    end
  endtask : pulses

  // Lamp state from the mode table; the flash divider is still low this early in a run.
  function automatic logic [2:0] led_exp(logic [1:0] m, logic [8:0] c);
    logic lnk, act, third;
    lnk   = spd ? sd : lk10;
    act   = rx | (tx & ~c[8]);
    third = m[0] ? (tx | rx) : (m[1] ? dup : (col & ~dup));
    led_exp = {third, spd, m[0] ? lnk : (lnk & ~act)};
    led_exp = (led_exp & ~c[5:3]) | (c[5:3] & c[2:0]);
  endfunction : led_exp

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  initial
  begin
    step(2);
    rst_n = 1'b1;
    step(5);
    rd(PHY_CONTROL_ADDR); chk_val(rd_q, 16'h0020);
    rd(INDICATOR_CONTROL_ADDR); chk_val(rd_q, 16'h0000);
    rd(5'h05); chk_val(rd_q, 16'h0000);
    chk_led(led_exp(2'h1, 9'h000));
    // Every mode first, then random modes, fields and status with writes one idle cycle apart.
    for (int i = 0; i < 40; i++)
    begin
      mode = (i < 4) ? i[1:0] : 2'($random(seed));
      ctl = 9'($random(seed));
      d = 16'($random(seed));
      d[6:5] = mode;
      {spd, sd, dup, tx, rx, col} = 6'($random(seed));
      wr(PHY_CONTROL_ADDR, d);
      wr(INDICATOR_CONTROL_ADDR, {7'h00, ctl});
      step(2);
      chk_led(led_exp(mode, ctl));
      rd(PHY_CONTROL_ADDR); chk_val(rd_q, d & 16'h0060);
      rd(INDICATOR_CONTROL_ADDR); chk_val(rd_q, {7'h00, ctl});
    end
    // Ten megabit link: a bad pulse restarts the count, seven good ones bring it up.
    wr(PHY_CONTROL_ADDR, 16'h0020);
    wr(INDICATOR_CONTROL_ADDR, 16'h0000);
    {spd, tx, rx} = 3'h0;
    pulses(6);
    bad = 1'b1; step(1); bad = 1'b0;
    pulses(6); chk_val({15'h0, link_up}, 16'h0000);
    pulses(1); chk_val({15'h0, link_up}, 16'h0001);
    lk10 = 1'b1; chk_led(led_exp(2'h1, 9'h000));
    step(LOSS - 8); chk_val({15'h0, link_up}, 16'h0001);
    step(12); lk10 = 1'b0; chk_led(led_exp(2'h1, 9'h000));
    pkt = 1'b1; step(1); pkt = 1'b0; step(2); chk_val({15'h0, link_up}, 16'h0001);
    results();
  end
endmodule : tb_top
